/* File: hw/sar_ctrl.sv */
// Operation
// - three-level select pin: low is shutdown, high unipolar, floating bipolar
// - between conversions result bits shift out on the asynchronous serial clock
// - result leaves the data pin most significant bit first
// - each conversion yields a 16-bit word, one bit decided per step
// - end-of-conversion idles low, rises a cycle after start, falls a cycle after end
// - data pin is driven only while chip select is low, else released
// - conversion starts on the next clock after convert goes low once acquired
// - while the reset pin is low nothing converts or calibrates
// - reset pin rising edge restarts control and runs a full calibration
// - host reads during conversion at clock rate or afterwards at serial rate
// - calibration runs by itself at power-up
// - calibration lasts about 14000 clocks with end-of-conversion high throughout
// - power-on delay of at least 500 ns precedes power-up calibration
// - correction codes are held digitally and survive shutdown
// - each upper bit's correction code is applied while that DAC bit is set during conversion
// - each calibration measurement is repeated many times and averaged
// - trial bit becomes one when comparator is low, zero when high, MSB down
// - start next clock if three clocks passed since last end, else fourth
// - serial read shows MSB on select, next bit per pulse, zeros after LSB
`include "sar_ctrl_defines.svh"

module sar_ctrl #(
    parameter int CAL_CYCLES = `SAR_CAL_CYCLES,
    parameter int NCAL       = `SAR_NCAL,
    parameter int CODE_W     = `SAR_CODE_W
) (
    input  wire logic                     MCLK,
    input  wire logic                     RST,
    input  wire logic                     SCLK,
    input  wire logic                     RESET_PIN_N,
    input  wire logic                     CONVERT_START_N,
    input  wire logic                     CS_N,
    input  wire logic                     RANGE_SHUTDOWN_SELECT_LOW,
    input  wire logic                     RANGE_SHUTDOWN_SELECT_HIGH,
    input  wire logic                     COMP_OUT,
    output logic                          EOC,
    output logic                          DOUT,
    output logic                          DOUT_OE,
    output logic                          SHUTDOWN,
    output logic                          BIPOLAR,
    output logic [`SAR_RESULT_W-1:0]      DAC_BITS,
    output logic [NCAL*CODE_W-1:0]        CAL_CODES
);
    localparam int PER_BIT = CAL_CYCLES / NCAL;
    localparam int ACC_W   = $clog2(PER_BIT + 1);
    localparam int SHIFT   = (ACC_W > CODE_W) ? ACC_W - CODE_W : 0;
    localparam int NSYNC   = 5;

    function automatic sar_ctrl_pkg::ser_idx_t gray2bin(input sar_ctrl_pkg::ser_idx_t g);
        sar_ctrl_pkg::ser_idx_t b;
        b[4] = g[4];
        for (int i = 3; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    sar_ctrl_pkg::state_e         state_q;
    logic [NSYNC-1:0]             pin_s1_q;
    logic [NSYNC-1:0]             pin_s2_q;
    logic                         rst_s;
    logic                         convert_start_n_n_s;
    logic                         cs_n_s;
    logic                         rst_prev_q;
    logic                         rst_rise;
    logic                         shdn_q;
    logic [7:0]                   por_q;
    logic [1:0]                   acq_q;
    logic                         acq_done;
    logic                         go_convert_start_n;
    logic [3:0]                   bit_q;
    logic [`SAR_RESULT_W-1:0]     result_q;
    logic [`SAR_RESULT_W-1:0]     res_d;
    logic [`SAR_RESULT_W-1:0]     dac_q;
    logic [15:0]                  cal_cnt_q;
    logic [3:0]                   cal_idx_q;
    logic [15:0]                  acc_q;
    logic                         cal_last;
    logic [CODE_W-1:0]            codes_q [NCAL];
    logic                         busy;
    logic                         eoc_q;
    logic                         dout_q;
    logic                         oe_q;
    logic                         bip_q;
    sar_ctrl_pkg::ser_idx_t       scnt_q;
    sar_ctrl_pkg::ser_idx_t       sgray_q;
    sar_ctrl_pkg::ser_idx_t       sg_s1_q;
    sar_ctrl_pkg::ser_idx_t       sg_s2_q;
    sar_ctrl_pkg::ser_idx_t       sidx;
    logic [15:0]                  cal_run_q;
    logic [4:0]                   convert_start_n_run_q;

    // pins are asynchronous to MCLK; the first stage feeds only the second
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_s1_q <= 5'h06;
            pin_s2_q <= 5'h06;
        end else begin
            pin_s1_q <= {RANGE_SHUTDOWN_SELECT_HIGH, RANGE_SHUTDOWN_SELECT_LOW, CS_N, CONVERT_START_N, RESET_PIN_N};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign rst_s    = pin_s2_q[0];
    assign convert_start_n_n_s = pin_s2_q[1];
    assign cs_n_s   = pin_s2_q[2];
    assign rst_rise = rst_s & ~rst_prev_q;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            rst_prev_q <= 1'b0;
            shdn_q     <= 1'b0;
            bip_q      <= 1'b0;
        end else begin
            rst_prev_q <= rst_s;
            shdn_q     <= pin_s2_q[3];
            bip_q      <= ~pin_s2_q[3] & ~pin_s2_q[4];
        end
    end

    assign acq_done = (acq_q == `SAR_ACQ_MIN);
    // extra convert pulses while busy are ignored: only idle looks at them
    assign go_convert_start_n  = rst_s && !shdn_q && acq_done &&
                      ((state_q == sar_ctrl_pkg::ST_IDLE && !convert_start_n_n_s) ||
                       state_q == sar_ctrl_pkg::ST_ACQ);
    assign cal_last = (cal_cnt_q == 16'(PER_BIT - 1)) && (cal_idx_q == 4'(NCAL - 1));

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= sar_ctrl_pkg::ST_POR;
        end else if (!rst_s && state_q != sar_ctrl_pkg::ST_POR) begin
            state_q <= sar_ctrl_pkg::ST_HALT;
        end else begin
            unique case (state_q)
                sar_ctrl_pkg::ST_HALT: begin
                    if (rst_rise) begin
                        state_q <= sar_ctrl_pkg::ST_CAL;
                    end
                end
                sar_ctrl_pkg::ST_POR: begin
                    if (por_q == 8'(`SAR_PON_CYC - 1)) begin
                        state_q <= rst_s ? sar_ctrl_pkg::ST_CAL : sar_ctrl_pkg::ST_HALT;
                    end
                end
                sar_ctrl_pkg::ST_CAL: begin
                    if (cal_last) begin
                        state_q <= sar_ctrl_pkg::ST_IDLE;
                    end
                end
                sar_ctrl_pkg::ST_IDLE: begin
                    if (go_convert_start_n) begin
                        state_q <= sar_ctrl_pkg::ST_CONVERT_START_N;
                    end else if (!convert_start_n_n_s && !shdn_q) begin
                        state_q <= sar_ctrl_pkg::ST_ACQ;
                    end
                end
                sar_ctrl_pkg::ST_ACQ: begin
                    if (shdn_q) begin
                        state_q <= sar_ctrl_pkg::ST_IDLE;
                    end else if (go_convert_start_n) begin
                        state_q <= sar_ctrl_pkg::ST_CONVERT_START_N;
                    end
                end
                sar_ctrl_pkg::ST_CONVERT_START_N: begin
                    if (bit_q == 4'h0) begin
                        state_q <= sar_ctrl_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST || state_q != sar_ctrl_pkg::ST_POR) begin
            por_q <= 8'h00;
        end else begin
            por_q <= por_q + 8'h01;
        end
    end

    // track/hold settles for a guaranteed number of clocks after every conversion
    always_ff @(posedge MCLK) begin
        if (RST) begin
            acq_q <= 2'h0;
        end else if (state_q == sar_ctrl_pkg::ST_CONVERT_START_N) begin
            acq_q <= 2'h0;
        end else if (!acq_done) begin
            acq_q <= acq_q + 2'h1;
        end
    end

    always_comb begin
        res_d        = result_q;
        res_d[bit_q] = ~COMP_OUT;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            bit_q    <= 4'h0;
            result_q <= '0;
            dac_q    <= '0;
        end else if (state_q == sar_ctrl_pkg::ST_CONVERT_START_N) begin
            result_q <= res_d;
            bit_q    <= bit_q - 4'h1;
            dac_q    <= res_d | ((bit_q != 4'h0) ? (16'h0001 << (bit_q - 4'h1)) : 16'h0000);
        end else if (go_convert_start_n) begin
            result_q <= '0;
            bit_q    <= 4'hf;
            dac_q    <= `SAR_MSB_TRIAL;
        end else if (state_q == sar_ctrl_pkg::ST_CAL) begin
            dac_q    <= 16'h8000 >> cal_idx_q;
        end else begin
            dac_q    <= '0;
        end
    end

    // averaging: count comparator lows over many trials, keep the top bits
    always_ff @(posedge MCLK) begin
        if (RST || state_q != sar_ctrl_pkg::ST_CAL) begin
            cal_cnt_q <= 16'h0000;
            cal_idx_q <= 4'h0;
            acc_q     <= 16'h0000;
        end else if (cal_cnt_q == 16'(PER_BIT - 1)) begin
            cal_cnt_q <= 16'h0000;
            cal_idx_q <= cal_idx_q + 4'h1;
            acc_q     <= 16'h0000;
        end else begin
            cal_cnt_q <= cal_cnt_q + 16'h0001;
            acc_q     <= acc_q + {15'h0000, ~COMP_OUT};
        end
    end

    // codes are plain flops, so shutdown of the analog part cannot erase them
    generate
        for (genvar k = 0; k < NCAL; k++) begin : g_cal
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    codes_q[k] <= '0;
                end else if (state_q == sar_ctrl_pkg::ST_CAL && cal_idx_q == 4'(k) &&
                             cal_cnt_q == 16'(PER_BIT - 1)) begin
                    codes_q[k] <= CODE_W'(acc_q >> SHIFT);
                end
            end
            assign CAL_CODES[k*CODE_W +: CODE_W] =
                (state_q == sar_ctrl_pkg::ST_CONVERT_START_N && dac_q[15-k]) ? codes_q[k] : '0;
        end
    endgenerate

    assign busy = (state_q == sar_ctrl_pkg::ST_CONVERT_START_N) || (state_q == sar_ctrl_pkg::ST_CAL);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            eoc_q <= 1'b0;
        end else begin
            eoc_q <= busy;
        end
    end

    // serial clock domain: only a gray-coded pulse count leaves it
    always_ff @(negedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            scnt_q  <= '0;
            sgray_q <= '0;
        end else if (scnt_q != `SAR_SER_LAST) begin
            scnt_q  <= scnt_q + 5'h01;
            sgray_q <= (scnt_q + 5'h01) ^ ((scnt_q + 5'h01) >> 1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            sg_s1_q <= '0;
            sg_s2_q <= '0;
        end else begin
            sg_s1_q <= sgray_q;
            sg_s2_q <= sg_s1_q;
        end
    end

    assign sidx = gray2bin(sg_s2_q);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            dout_q <= 1'b0;
        end else if (state_q == sar_ctrl_pkg::ST_CONVERT_START_N) begin
            dout_q <= ~COMP_OUT;
        end else if (sidx < `SAR_SER_LAST) begin
            dout_q <= result_q[4'hf - sidx[3:0]];
        end else begin
            dout_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ~cs_n_s;
        end
    end

    assign EOC      = eoc_q;
    assign DOUT     = dout_q;
    assign DOUT_OE  = oe_q;
    assign SHUTDOWN = shdn_q;
    assign BIPOLAR  = bip_q;
    assign DAC_BITS = dac_q;

    always_ff @(posedge MCLK) begin
        if (RST || state_q != sar_ctrl_pkg::ST_CAL) begin
            cal_run_q <= 16'h0000;
        end else begin
            cal_run_q <= cal_run_q + 16'h0001;
        end
    end

    // step count of the running conversion, checked at its end instead of a long repetition
    always_ff @(posedge MCLK) begin
        if (RST || state_q != sar_ctrl_pkg::ST_CONVERT_START_N) begin
            convert_start_n_run_q <= 5'h00;
        end else begin
            convert_start_n_run_q <= convert_start_n_run_q + 5'h01;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence convert_start_n_begins;
        (state_q != sar_ctrl_pkg::ST_CONVERT_START_N) ##1 (state_q == sar_ctrl_pkg::ST_CONVERT_START_N);
    endsequence

    sequence convert_start_n_ends;
        (state_q == sar_ctrl_pkg::ST_CONVERT_START_N) ##1 (state_q == sar_ctrl_pkg::ST_IDLE);
    endsequence

    chk_eoc_rise: assert property (convert_start_n_begins |=> EOC)
        else $error("end-of-conversion did not rise after start");
    chk_eoc_fall: assert property ($fell(busy) |=> !EOC)
        else $error("end-of-conversion did not fall after end");
    chk_msb_first: assert property (convert_start_n_begins |-> DAC_BITS == `SAR_MSB_TRIAL)
        else $error("first trial is not the MSB");
    chk_sar_decide: assert property (state_q == sar_ctrl_pkg::ST_CONVERT_START_N |=>
        result_q[$past(bit_q)] == !$past(COMP_OUT))
        else $error("trial bit disagrees with comparator");
    chk_convert_start_n_steps: assert property (convert_start_n_ends |-> $past(convert_start_n_run_q) == 5'(`SAR_RESULT_W - 1))
        else $error("conversion is not sixteen steps");
    chk_acq_gap: assert property (convert_start_n_ends |-> (state_q != sar_ctrl_pkg::ST_CONVERT_START_N)[*3])
        else $error("conversion restarted inside acquisition");
    chk_acq_start: assert property ((state_q == sar_ctrl_pkg::ST_ACQ && acq_done && !shdn_q && rst_s)
        |=> state_q == sar_ctrl_pkg::ST_CONVERT_START_N)
        else $error("acquired but conversion did not start");
    chk_halt_hold: assert property (!rst_s |=> state_q inside {sar_ctrl_pkg::ST_HALT, sar_ctrl_pkg::ST_POR})
        else $error("active while reset pin low");
    chk_shdn_block: assert property ((shdn_q && state_q != sar_ctrl_pkg::ST_CONVERT_START_N)
        |=> state_q != sar_ctrl_pkg::ST_CONVERT_START_N)
        else $error("conversion started in shutdown");
    chk_cal_len: assert property ((state_q == sar_ctrl_pkg::ST_IDLE && $past(state_q) == sar_ctrl_pkg::ST_CAL)
        |-> $past(cal_run_q) == 16'(PER_BIT * NCAL - 1))
        else $error("calibration length wrong");
    chk_oe_cs: assert property (cs_n_s |=> !DOUT_OE)
        else $error("data pin driven while deselected");
endmodule

/* File: hw/sar_ctrl_defines.svh */
`ifndef SAR_CTRL_DEFINES_SVH
`define SAR_CTRL_DEFINES_SVH

`define SAR_RESULT_W      16
`define SAR_MSB_TRIAL     16'h8000
`define SAR_ACQ_MIN       2'h3
`define SAR_CLK_PERIOD_NS 10
`define SAR_PON_NS        500
`define SAR_PON_CYC       ((`SAR_PON_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_CAL_CYCLES    14000
`define SAR_NCAL          10
`define SAR_CODE_W        8
`define SAR_SER_LAST      5'h10

`endif

/* File: hw/sar_ctrl_pkg.sv */
package sar_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_HALT,
        ST_POR,
        ST_CAL,
        ST_IDLE,
        ST_ACQ,
        ST_CONVERT_START_N
    } state_e;

    typedef logic [4:0] ser_idx_t;
endpackage

/* File: test/serial_host_model.sv */
module serial_host_model (
    input  wire logic MCLK,
    input  wire logic DOUT,
    input  wire logic DOUT_OE,
    output logic      CS_N,
    output logic      SCLK
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pin_q = 1'b0;
    logic pin;

    // no pull resistor on the data line, so a released pin toggles and cannot pass as data
    assign pin = DOUT_OE ? DOUT : ~pin_q;
    always @(posedge MCLK) pin_q <= pin;

    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
    end

    // link clock stands still between pulses; the extra wait holds the bit rate at 5 Mbps
    task automatic pulse();
        #62.5 SCLK = 1'b1;
        #62.5 SCLK = 1'b0;
        repeat (8) @(posedge MCLK);
    endtask

    task automatic read_word(output logic [15:0] w, output logic extra);
        @(posedge MCLK) CS_N <= 1'b0;
        repeat (8) @(posedge MCLK);
        for (int k = 16; k >= 0; k--) begin
            if (k > 0) w[k-1] = pin;
            else extra = pin;
            if (k > 0) pulse();
        end
        @(posedge MCLK) CS_N <= 1'b1;
    endtask
endmodule

/* File: test/sar_ctrl_bench.sv */
module sar_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CAL = 100;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic        RESET_PIN_N = 1'b1;
    logic        CONVERT_START_N = 1'b1;
    logic        sel_low = 1'b0;
    logic        sel_high = 1'b1;
    logic [15:0] vin = 16'h0000;
    logic        cs_n, sclk, eoc, dout, dout_oe, shutdown, bipolar, comp;
    logic [15:0] dac;
    logic [79:0] cal_codes;
    int          n_errors = 0;
    int          compares = 0;
    int          cycles = 0;

    // ideal comparator: output low while the trial code does not exceed the input
    assign comp = dac > vin;

    sar_ctrl #(.CAL_CYCLES(CAL)) u_sar_ctrl (
        .MCLK(MCLK), .RST(RST), .SCLK(sclk), .RESET_PIN_N(RESET_PIN_N),
        .CONVERT_START_N(CONVERT_START_N), .CS_N(cs_n),
        .RANGE_SHUTDOWN_SELECT_LOW(sel_low), .RANGE_SHUTDOWN_SELECT_HIGH(sel_high),
        .COMP_OUT(comp), .EOC(eoc), .DOUT(dout), .DOUT_OE(dout_oe),
        .SHUTDOWN(shutdown), .BIPOLAR(bipolar), .DAC_BITS(dac), .CAL_CODES(cal_codes)
    );

    serial_host_model u_serial_host_model (
        .MCLK(MCLK), .DOUT(dout), .DOUT_OE(dout_oe), .CS_N(cs_n), .SCLK(sclk)
    );

    initial begin
        forever #5 MCLK = ~MCLK;
    end

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic cmp1(string what, logic exp, logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cmp16(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wait_eoc(logic lvl, int lim, output int n);
        n = 0;
        while (eoc !== lvl && n < lim) begin
            @(posedge MCLK);
            n++;
        end
    endtask

    task automatic t_power_up();
        int n;
        repeat (40) @(posedge MCLK);
        cmp1("eoc in power-on wait", 1'b0, eoc);
        wait_eoc(1'b1, 40, n);
        cmp1("cal starts alone", 1'b1, eoc);
        wait_eoc(1'b0, 2 * CAL, n);
        cmp1("cal length", 1'b1, n >= CAL - 2 && n <= CAL + 2);
    endtask

    task automatic t_convert(logic [15:0] v);
        int n;
        logic [15:0] w;
        logic extra;
        vin = v;
        @(posedge MCLK) CONVERT_START_N <= 1'b0;
        wait_eoc(1'b1, 12, n);
        CONVERT_START_N <= 1'b1;
        cmp1("eoc rises", 1'b1, eoc);
        wait_eoc(1'b0, 24, n);
        cmp1("eoc frame", 1'b1, n >= 15 && n <= 18);
        cmp1("idle before read", 1'b0, dout_oe);
        cmp1("codes off when idle", 1'b1, cal_codes == 80'h0);
        u_serial_host_model.read_word(w, extra);
        cmp16("serial result", v, w);
        cmp1("bit after lsb", 1'b0, extra);
        repeat (6) @(posedge MCLK);
        cmp1("pin released", 1'b0, dout_oe);
    endtask

    task automatic t_back_to_back();
        int n;
        @(posedge MCLK) CONVERT_START_N <= 1'b0;
        wait_eoc(1'b1, 12, n);
        wait_eoc(1'b0, 24, n);
        wait_eoc(1'b1, 12, n);
        CONVERT_START_N <= 1'b1;
        cmp1("acquire gap", 1'b1, n >= 3 && n <= 6);
        wait_eoc(1'b0, 24, n);
    endtask

    task automatic t_shutdown();
        sel_low <= 1'b1;
        sel_high <= 1'b0;
        repeat (6) @(posedge MCLK);
        cmp1("shutdown", 1'b1, shutdown);
        CONVERT_START_N <= 1'b0;
        repeat (30) @(posedge MCLK);
        cmp1("no convert in shutdown", 1'b0, eoc);
        CONVERT_START_N <= 1'b1;
        sel_low <= 1'b0;
        repeat (6) @(posedge MCLK);
        cmp1("left shutdown", 1'b0, shutdown);
        cmp1("floating is bipolar", 1'b1, bipolar);
        sel_high <= 1'b1;
        repeat (6) @(posedge MCLK);
        cmp1("high is unipolar", 1'b0, bipolar);
        t_convert(16'h3c01);
    endtask

    task automatic t_reset_pin();
        int n;
        RESET_PIN_N <= 1'b0;
        CONVERT_START_N <= 1'b0;
        repeat (40) @(posedge MCLK);
        cmp1("halted", 1'b0, eoc);
        CONVERT_START_N <= 1'b1;
        RESET_PIN_N <= 1'b1;
        wait_eoc(1'b1, 10, n);
        cmp1("recal starts", 1'b1, eoc);
        wait_eoc(1'b0, CAL + 10, n);
        cmp1("recal length", 1'b1, n >= CAL - 2 && n <= CAL + 2);
        t_convert(16'h8000);
    endtask

    initial begin
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        t_power_up();
        t_convert(16'ha5c3);
        t_convert(16'hffff);
        t_convert(16'h0000);
        t_back_to_back();
        t_shutdown();
        t_reset_pin();
        wrap_up();
    end
endmodule
